/* otg_voltage_and_sys_threshold_regs.sv */
// I2C register block: system low threshold, fast swap, OTG voltage
// Functional notes
// - Threshold code sits in bits 7..2, weights 3200 mV down to 100 mV.
// - Threshold reset: 100 mV bit set; 1600/800/200 mV set only multi-cell.
// - Track bit makes internal threshold follow threshold one input.
// - Fast swap bit resets off; its rise blanks power stage 200 us.
// - High impedance enable forces the fast swap bit to zero.
// - During OTG operation target is clamped to 3 V .. 24 V.
// - OTG writes outside the allowed range are dropped, old value kept.
// - OTG code is bits 13..2, weights 16384 mV down to 8 mV.
// - Bits 15..14 must be zero; bits 1..0 are ignored.
// - Trip voltage is threshold code times 100 mV plus 3.2 V.
// - Single-cell without tracking limits threshold to 3.9 V, upper code bits ignored.
// - Low status asserts after system voltage stays below trip 5 us.
`timescale 1ns/1ps
`default_nettype none
`include "otg_vsys_defs.svh"
module otg_voltage_and_sys_threshold_regs
#(
	parameter logic [6:0] DEV_ADDR         = 7'h6B,
	parameter int unsigned FRS_BLANK_CYCLES = `FRS_BLANK_US * `CLK_MHZ
)
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        multi_cell,
	input  wire logic        high_impedance_enable,
	input  wire logic        otg_active,
	input  wire logic [5:0]  sys_low_threshold_one,
	input  wire logic [13:0] sys_mv,
	output logic [14:0]      otg_target_mv,
	output logic [13:0]      sys_trip_mv,
	output logic             threshold_track_enable,
	output logic             fast_swap_enable,
	output logic             power_stage_off,
	output logic             sys_low_status
);
	import otg_vsys_pkg::*;

	localparam logic [15:0] OTG_RST    = `OTG_RESET;
	localparam logic [7:0]  PROT_1S    = `PROT_RESET_1S;
	localparam logic [7:0]  PROT_MS    = `PROT_RESET_MS;
	localparam logic [11:0] OTG_MIN    = 12'(`OTG_MIN_MV / `OTG_LSB_MV);
	localparam logic [11:0] OTG_MAX    = 12'(`OTG_MAX_MV / `OTG_LSB_MV);
	localparam logic [15:0] BLANK_LOAD = 16'(FRS_BLANK_CYCLES);
	localparam logic [9:0]  DGL_LAST   =
		10'(`SYS_DEGLITCH_NS / `CLK_PERIOD_NS - 1);

	localparam core_state_t CORE_RESET = '{
		scl_sync:     3'h7,
		sda_sync:     3'h7,
		scl_f:        1'b1,
		sda_f:        1'b1,
		st:           ST_IDLE,
		otg_word:     OTG_RST,
		otg_lo_stage: OTG_RST[7:0],
		prot_lo:      PROT_1S,
		default:      '0
	};

	core_state_t r;
	core_state_t n;

	// Byte seen by the host at a register pointer; unmapped reads as zero
	function automatic logic [7:0] read_byte(input logic [7:0] ptr,
		input logic [7:0] prot, input logic [15:0] word);
		logic [7:0] v;
		unique case (ptr)
			`REG_OTG_LO:  v = word[7:0];
			`REG_OTG_HI:  v = word[15:8];
			`REG_PROT_LO: v = prot;
			default:      v = 8'h00;
		endcase
		return v;
	endfunction

	// Accepts a word only with clear reserved bits and an in-range code
	function automatic logic otg_word_ok(input logic [15:0] word);
		logic [11:0] code;
		code = word[`OTG_CODE_MSB:`OTG_CODE_LSB];
		return (word[`OTG_RSV_MSB:`OTG_RSV_LSB] == 2'b00) &&
			(code >= OTG_MIN) && (code <= OTG_MAX);
	endfunction

	always_comb
	begin
		logic        scl_new;
		logic        sda_new;
		logic        scl_rise;
		logic        scl_fall;
		logic        start;
		logic        stop;
		logic        wr_en;
		logic [7:0]  wr_addr;
		logic [7:0]  wr_data;
		logic [7:0]  rd;
		logic [15:0] word;
		logic [5:0]  prog;
		logic [5:0]  eff;
		logic [11:0] code;
		scl_new  = r.scl_f;
		sda_new  = r.sda_f;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start    = 1'b0;
		stop     = 1'b0;
		wr_en    = 1'b0;
		wr_addr  = 8'h00;
		wr_data  = 8'h00;
		rd       = 8'h00;
		word     = 16'h0000;
		prog     = 6'h00;
		eff      = 6'h00;
		code     = 12'h000;
		n = r;

		// Pin synchronisers; a level counts once stages two and three agree
		n.scl_sync   = {r.scl_sync[1:0], scl_in};
		n.sda_sync   = {r.sda_sync[1:0], sda_in};
		n.strap_sync = {r.strap_sync[1:0], multi_cell};
		if (r.scl_sync[1] == r.scl_sync[2])
			scl_new = r.scl_sync[2];
		if (r.sda_sync[1] == r.sda_sync[2])
			sda_new = r.sda_sync[2];
		n.scl_f  = scl_new;
		n.sda_f  = sda_new;
		scl_rise = scl_new & ~r.scl_f;
		scl_fall = ~scl_new & r.scl_f;
		start    = scl_new & r.scl_f & r.sda_f & ~sda_new;
		stop     = scl_new & r.scl_f & ~r.sda_f & sda_new;

		if (start)
		begin
			n.st        = ST_ADDR;
			n.cnt       = 4'h0;
			n.sda_drive = 1'b0;
		end
		else if (stop)
		begin
			n.st        = ST_IDLE;
			n.sda_drive = 1'b0;
		end
		else if (scl_rise)
		begin
			unique case (r.st)
				ST_ADDR, ST_PTR, ST_WDATA:
				begin
					n.sh  = {r.sh[6:0], sda_new};
					n.cnt = r.cnt + 4'h1;
				end
				ST_RDATA:
					n.cnt = r.cnt + 4'h1;
				ST_RACK:
					n.nack = sda_new;
				default:
					n.cnt = r.cnt;
			endcase
		end
		else if (scl_fall)
		begin
			unique case (r.st)
				ST_IDLE:
					n.sda_drive = 1'b0;
				ST_ADDR:
					if (r.cnt == 4'h8)
					begin
						n.cnt = 4'h0;
						if (r.sh[7:1] == DEV_ADDR)
						begin
							n.rw        = r.sh[0];
							n.st        = ST_ADDR_ACK;
							n.sda_drive = 1'b1;
						end
						else
							n.st = ST_IDLE;
					end
				ST_PTR:
					if (r.cnt == 4'h8)
					begin
						n.cnt       = 4'h0;
						n.ptr       = r.sh;
						n.st        = ST_PTR_ACK;
						n.sda_drive = 1'b1;
					end
				ST_WDATA:
					if (r.cnt == 4'h8)
					begin
						n.cnt       = 4'h0;
						wr_en       = 1'b1;
						wr_addr     = r.ptr;
						wr_data     = r.sh;
						n.ptr       = r.ptr + 8'h01;
						n.st        = ST_WDATA_ACK;
						n.sda_drive = 1'b1;
					end
				ST_ADDR_ACK:
					if (r.rw)
					begin
						rd          = read_byte(r.ptr, r.prot_lo, r.otg_word);
						n.sh        = rd;
						n.sda_drive = ~rd[7];
						n.st        = ST_RDATA;
					end
					else
					begin
						n.sda_drive = 1'b0;
						n.st        = ST_PTR;
					end
				ST_PTR_ACK, ST_WDATA_ACK:
				begin
					n.sda_drive = 1'b0;
					n.st        = ST_WDATA;
				end
				ST_RDATA:
					if (r.cnt == 4'h8)
					begin
						n.cnt       = 4'h0;
						n.sda_drive = 1'b0;
						n.ptr       = r.ptr + 8'h01;
						n.st        = ST_RACK;
					end
					else
					begin
						n.sh        = {r.sh[6:0], 1'b0};
						n.sda_drive = ~r.sh[6];
					end
				ST_RACK:
					if (r.nack)
						n.st = ST_IDLE;
					else
					begin
						rd          = read_byte(r.ptr, r.prot_lo, r.otg_word);
						n.sh        = rd;
						n.sda_drive = ~rd[7];
						n.st        = ST_RDATA;
					end
				default:
				begin
					n.st        = ST_IDLE;
					n.sda_drive = 1'b0;
				end
			endcase
		end

		// Cell-count strap taken once, waiting until stages two and three agree
		if ((r.settle != 2'h2) && (r.settle != `SYNC_SETTLE))
			n.settle = r.settle + 2'h1;
		if ((r.settle == 2'h2) && (r.strap_sync[1] == r.strap_sync[2]))
		begin
			n.settle  = `SYNC_SETTLE;
			n.multi_r = r.strap_sync[2];
			n.prot_lo[`PROT_TH_MSB:`PROT_TH_LSB] = r.strap_sync[2] ?
				PROT_MS[`PROT_TH_MSB:`PROT_TH_LSB] :
				PROT_1S[`PROT_TH_MSB:`PROT_TH_LSB];
		end

		if (wr_en)
		begin
			unique case (wr_addr)
				`REG_PROT_LO:
					n.prot_lo = wr_data;
				`REG_OTG_LO:
					n.otg_lo_stage = wr_data;
				`REG_OTG_HI:
				begin
					word = {wr_data, r.otg_lo_stage};
					if (otg_word_ok(word))
						n.otg_word = {word[15:2], 2'b00};
				end
				default:
					n.otg_lo_stage = r.otg_lo_stage;
			endcase
		end

		if (high_impedance_enable)
			n.prot_lo[`PROT_FRS_BIT] = 1'b0;

		// Fast swap enable edge blanks the power stage
		n.frs_prev = r.prot_lo[`PROT_FRS_BIT];
		if (r.prot_lo[`PROT_FRS_BIT] & ~r.frs_prev)
			n.blank_cnt = BLANK_LOAD;
		else if (r.blank_cnt != 16'h0000)
			n.blank_cnt = r.blank_cnt - 16'h0001;

		prog = r.prot_lo[`PROT_TH_MSB:`PROT_TH_LSB];
		if (!r.multi_r)
			prog = prog & `TH_1S_MASK;
		eff = r.prot_lo[`PROT_TRACK_BIT] ? sys_low_threshold_one : prog;
		n.trip_mv = 14'(`TH_OFFSET_MV) +
			14'(eff) * 14'(`TH_STEP_MV);
		if (sys_mv < r.trip_mv)
		begin
			if (r.dgl_cnt == DGL_LAST)
				n.sys_low = 1'b1;
			else
				n.dgl_cnt = r.dgl_cnt + 10'h001;
		end
		else
		begin
			n.dgl_cnt = 10'h000;
			n.sys_low = 1'b0;
		end
		code = r.otg_word[`OTG_CODE_MSB:`OTG_CODE_LSB];
		if (otg_active)
		begin
			if (code < OTG_MIN)
				code = OTG_MIN;
			else if (code > OTG_MAX)
				code = OTG_MAX;
		end
		n.target_mv = 15'(code) * 15'(`OTG_LSB_MV);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			r <= CORE_RESET;
		else
			r <= n;
	end

	// Open-drain data line: only ever pulled low
	assign sda_out                = 1'b0;
	assign sda_oe                 = r.sda_drive;
	assign otg_target_mv          = r.target_mv;
	assign sys_trip_mv            = r.trip_mv;
	assign threshold_track_enable = r.prot_lo[`PROT_TRACK_BIT];
	assign fast_swap_enable       = r.prot_lo[`PROT_FRS_BIT];
	assign power_stage_off        = (r.blank_cnt != 16'h0000);
	assign sys_low_status         = r.sys_low;
endmodule
`default_nettype wire

/* otg_vsys_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef OTG_VSYS_DEFS_SVH
`define OTG_VSYS_DEFS_SVH

`define REG_OTG_LO      8'h06
`define REG_OTG_HI      8'h07
`define REG_PROT_LO     8'h3E

`define OTG_RESET       16'h09C4
`define PROT_RESET_1S   8'h04
`define PROT_RESET_MS   8'h6C

`define PROT_TH_MSB     7
`define PROT_TH_LSB     2
`define PROT_TRACK_BIT  1
`define PROT_FRS_BIT    0
`define OTG_RSV_MSB     15
`define OTG_RSV_LSB     14
`define OTG_CODE_MSB    13
`define OTG_CODE_LSB    2

`define OTG_MIN_MV      3000
`define OTG_MAX_MV      24000
`define OTG_LSB_MV      8
`define TH_OFFSET_MV    3200
`define TH_STEP_MV      100
`define TH_1S_MASK      6'h07

`define CLK_MHZ         200
`define CLK_PERIOD_NS   5
`define FRS_BLANK_US    200
`define SYS_DEGLITCH_NS 5000
`define SYNC_SETTLE     2'h3

`endif

/* otg_vsys_pkg.sv */
// Types shared by the threshold and output voltage register block
package otg_vsys_pkg;

	typedef enum logic [3:0]
	{
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h3,
		ST_PTR       = 4'h2,
		ST_PTR_ACK   = 4'h6,
		ST_WDATA     = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA     = 4'h4,
		ST_RACK      = 4'hC
	} i2c_state_t;

	typedef struct packed
	{
		logic [2:0]  scl_sync;
		logic [2:0]  sda_sync;
		logic        scl_f;
		logic        sda_f;
		i2c_state_t  st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  ptr;
		logic        rw;
		logic        nack;
		logic        sda_drive;
		logic [7:0]  otg_lo_stage;
		logic [15:0] otg_word;
		logic [7:0]  prot_lo;
		logic [2:0]  strap_sync;
		logic [1:0]  settle;
		logic        multi_r;
		logic        frs_prev;
		logic [15:0] blank_cnt;
		logic [9:0]  dgl_cnt;
		logic        sys_low;
		logic [13:0] trip_mv;
		logic [14:0] target_mv;
	} core_state_t;

endpackage

/* otg_vsys_asserts.sv */
// Port checks for the threshold and OTG voltage register block
`timescale 1ns/1ps
`default_nettype none
`include "otg_vsys_defs.svh"
module otg_vsys_asserts
#(
	parameter int unsigned FRS_BLANK_CYCLES = `FRS_BLANK_US * `CLK_MHZ
)
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        multi_cell,
	input wire logic        high_impedance_enable,
	input wire logic        otg_active,
	input wire logic [5:0]  sys_low_threshold_one,
	input wire logic [13:0] sys_mv,
	input wire logic [14:0] otg_target_mv,
	input wire logic [13:0] sys_trip_mv,
	input wire logic        threshold_track_enable,
	input wire logic        fast_swap_enable,
	input wire logic        power_stage_off,
	input wire logic        sys_low_status
);
	logic [15:0] off_r;
	logic [10:0] low_r;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Lengths of the blank pulse and of the run below the trip level
	always_ff @(posedge clk_sys or posedge sys_rst)
		if (sys_rst)
		begin
			off_r <= 16'h0;
			low_r <= 11'h0;
		end
		else
		begin
			off_r <= power_stage_off ? off_r + 16'h1 : 16'h0;
			low_r <= (sys_mv < sys_trip_mv) ? low_r + 11'h1 : 11'h0;
		end
	a_trip_tracks_one: assert property (
		threshold_track_enable |=>
		sys_trip_mv == 3200 + 100 * $past(sys_low_threshold_one))
		else $error("trip ignores threshold one");
	a_cell_trip_cap: assert property (
		(!multi_cell && !threshold_track_enable) [*2] |->
		sys_trip_mv <= 14'hF3C)
		else $error("single cell trip too high");
	a_hiz_clears_swap: assert property (
		high_impedance_enable [*2] |-> !fast_swap_enable)
		else $error("swap set under high impedance");
	a_blank_on_swap: assert property (
		$rose(power_stage_off) |-> fast_swap_enable)
		else $error("blank without swap");
	a_blank_length: assert property (
		$fell(power_stage_off) |-> off_r == FRS_BLANK_CYCLES)
		else $error("blank length wrong");
	a_low_deglitch: assert property (
		$rose(sys_low_status) |-> low_r >= 11'h3E8)
		else $error("low status too early");
	a_low_release: assert property (
		(sys_mv >= sys_trip_mv) [*2] |-> !sys_low_status)
		else $error("low status held");
	a_otg_clamp_range: assert property (
		otg_active [*2] |-> otg_target_mv inside {[15'hBB8:15'h5DC0]})
		else $error("target outside clamp");
	c_blank: cover property ($fell(power_stage_off));
	c_low: cover property ($rose(sys_low_status));
	c_clamp: cover property (otg_active [*2]);
endmodule
bind otg_voltage_and_sys_threshold_regs otg_vsys_asserts
	#(.FRS_BLANK_CYCLES(FRS_BLANK_CYCLES)) chk_i
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .multi_cell(multi_cell),
		.high_impedance_enable(high_impedance_enable),
		.otg_active(otg_active),
		.sys_low_threshold_one(sys_low_threshold_one),
		.sys_mv(sys_mv), .otg_target_mv(otg_target_mv),
		.sys_trip_mv(sys_trip_mv),
		.threshold_track_enable(threshold_track_enable),
		.fast_swap_enable(fast_swap_enable),
		.power_stage_off(power_stage_off),
		.sys_low_status(sys_low_status)
	);
`default_nettype wire

/* otg_host_model.sv */
// I2C host model that reaches the register block
`timescale 1ns/1ps
`default_nettype none
module otg_host_model
#(
	parameter logic [6:0] DEV_ADDR = 7'h6B
)
(
	input  wire logic clk_sys,
	input  wire logic sda_oe,
	output var logic  scl,
	output wire logic sda
);
	logic drv = 1'b1;
	initial scl = 1'b1;
	// Open drain: the device only pulls low, the host releases to high
	assign sda = drv & ~sda_oe;
	task automatic step(input logic s, input logic d, output logic r);
		repeat (12) @(negedge clk_sys);
		r = sda;
		scl = s;
		drv = d;
	endtask
	task automatic bit_io(input logic b, output logic r);
		step(1'b0, b, r);
		step(1'b1, b, r);
		step(1'b0, b, r);
	endtask
	task automatic start();
		logic r;
		step(1'b0, 1'b1, r);
		step(1'b1, 1'b1, r);
		step(1'b1, 1'b0, r);
		step(1'b0, 1'b0, r);
	endtask
	task automatic stop();
		logic r;
		step(1'b0, 1'b0, r);
		step(1'b1, 1'b0, r);
		step(1'b1, 1'b1, r);
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q,
		output logic n);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, n);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic       n0, n1, n2;
		start();
		xfer({DEV_ADDR, 1'b0}, q, n0);
		xfer(p, q, n1);
		xfer(d, q, n2);
		stop();
		ok = ~(n0 | n1 | n2);
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] q;
		logic       n;
		start();
		xfer({DEV_ADDR, 1'b0}, q, n);
		xfer(p, q, n);
		start();
		xfer({DEV_ADDR, 1'b1}, q, n);
		xfer(8'hFF, d, n);
		stop();
	endtask
endmodule
`default_nettype wire

/* tb_otg_voltage_and_sys_threshold_regs.sv */
// Self-checking bench for the threshold and OTG voltage registers
`timescale 1ns/1ps
`default_nettype none
module tb_otg_voltage_and_sys_threshold_regs;
	logic        clk_sys, sys_rst, multi_cell, high_impedance_enable;
	logic        otg_active, sda_out, sda_oe, scl_in, sda_in, ok;
	logic        threshold_track_enable, fast_swap_enable;
	logic        power_stage_off, sys_low_status;
	logic [5:0]  sys_low_threshold_one = 6'h0A;
	logic [13:0] sys_mv, sys_trip_mv;
	logic [14:0] otg_target_mv;
	logic [7:0]  rdat;
	int          err_count = 0;
	int          cmp_count = 0;
	// Low byte, high byte, expected target
	logic [30:0] otab [5] = '{{8'hE0, 8'h2E, 15'h5DC0},
		{8'hE4, 8'h2E, 15'h5DC0}, {8'hDF, 8'h05, 15'h0BB8},
		{8'hD8, 8'h05, 15'h0BB8}, {8'hDC, 8'h45, 15'h0BB8}};
	otg_voltage_and_sys_threshold_regs #(.FRS_BLANK_CYCLES(300)) dut
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.multi_cell(multi_cell),
		.high_impedance_enable(high_impedance_enable),
		.otg_active(otg_active),
		.sys_low_threshold_one(sys_low_threshold_one),
		.sys_mv(sys_mv), .otg_target_mv(otg_target_mv),
		.sys_trip_mv(sys_trip_mv),
		.threshold_track_enable(threshold_track_enable),
		.fast_swap_enable(fast_swap_enable),
		.power_stage_off(power_stage_off),
		.sys_low_status(sys_low_status)
	);
	otg_host_model host (.clk_sys(clk_sys), .sda_oe(sda_oe),
		.scl(scl_in), .sda(sda_in));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic rchk(input logic [7:0] p, input logic [7:0] e);
		host.rd(p, rdat);
		chk({8'h00, rdat}, {8'h00, e});
	endtask
	task automatic wchk(input logic [7:0] p, input logic [7:0] d);
		host.wr(p, d, ok);
		chk({15'h0, ok}, 16'h1);
		cyc(2);
	endtask
	task automatic rst(input logic m);
		sys_rst = 1'b1;
		multi_cell = m;
		cyc(16);
		sys_rst = 1'b0;
		cyc(20);
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		err_count++;
		$display("MISMATCH %0t timeout", $time);
		conclude();
	end
	initial
	begin
		sys_rst = 1'b1;
		high_impedance_enable = 1'b0;
		otg_active = 1'b0;
		sys_mv = 14'h3FFF;
		rst(1'b1);
		rchk(8'h06, 8'hC4);
		rchk(8'h07, 8'h09);
		rchk(8'h3E, 8'h6C);
		rchk(8'h10, 8'h00);
		chk(16'(sys_trip_mv), 16'h170C);
		chk(16'(otg_target_mv), 16'h1388);
		chk({12'h0, sda_out, sda_oe, fast_swap_enable, power_stage_off},
			16'h0);
		$display("reset test done");
		wchk(8'h3E, 8'h16);
		chk(16'(sys_trip_mv), 16'h1068);
		chk({15'h0, threshold_track_enable}, 16'h1);
		sys_low_threshold_one = 6'h3F;
		cyc(2);
		chk(16'(sys_trip_mv), 16'h251C);
		wchk(8'h3E, 8'h14);
		chk(16'(sys_trip_mv), 16'h0E74);
		chk({15'h0, threshold_track_enable}, 16'h0);
		sys_mv = 14'h0E73;
		cyc(990);
		chk({15'h0, sys_low_status}, 16'h0);
		cyc(20);
		chk({15'h0, sys_low_status}, 16'h1);
		sys_mv = 14'h0E74;
		cyc(3);
		chk({15'h0, sys_low_status}, 16'h0);
		$display("threshold test done");
		wchk(8'h3E, 8'h15);
		chk({14'h0, fast_swap_enable, power_stage_off}, 16'h3);
		cyc(300);
		chk({15'h0, power_stage_off}, 16'h0);
		high_impedance_enable = 1'b1;
		cyc(2);
		chk({15'h0, fast_swap_enable}, 16'h0);
		wchk(8'h3E, 8'h15);
		rchk(8'h3E, 8'h14);
		high_impedance_enable = 1'b0;
		$display("swap test done");
		for (int i = 0; i < 5; i++)
		begin
			wchk(8'h06, otab[i][30:23]);
			wchk(8'h07, otab[i][22:15]);
			chk(16'(otg_target_mv), 16'(otab[i][14:0]));
		end
		rchk(8'h06, 8'hDC);
		otg_active = 1'b1;
		cyc(3);
		chk(16'(otg_target_mv), 16'h0BB8);
		otg_active = 1'b0;
		$display("otg test done");
		rst(1'b0);
		rchk(8'h3E, 8'h04);
		wchk(8'h3E, 8'hFC);
		chk(16'(sys_trip_mv), 16'h0F3C);
		$display("single cell test done");
		conclude();
	end
endmodule
`default_nettype wire
